// [verification/afe_sensor_model.sv]
// Purpose: Line sensor model driving sample pulses and pixel codes
// Assumes: One pixel per go pulse, reference level before data level
// Notes: Codes outside the pulses change every cycle, never hold stale
`default_nettype none
module afe_sensor_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [63:0] ref_lvl,
  input wire logic [63:0] dat_lvl,
  output logic ref_p,
  output logic dat_p,
  output logic [63:0] code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] st_r;
  logic [63:0] noise_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= 3'h0;
      ref_p <= 1'b0;
      dat_p <= 1'b0;
      code <= 64'h0;
      noise_r <= 64'h5a5a_a5a5_3c3c_c3c3;
    end else begin
      noise_r <= noise_r + 64'h1111_1111_1111_1111;
      // Gap cycle keeps the two pulses apart even in sample-hold
      ref_p <= (st_r == 3'h1);
      dat_p <= (st_r == 3'h3);
      if (st_r == 3'h1) code <= ref_lvl;
      else if (st_r == 3'h3) code <= dat_lvl;
      else code <= noise_r;
      if (go) st_r <= 3'h1;
      else if (st_r != 3'h0 && st_r < 3'h4) st_r <= st_r + 3'h1;
      else st_r <= 3'h0;
    end
  end
endmodule : afe_sensor_model
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for input mode and pin select
// Assumes: AXI4-Lite master tasks, sensor model on the sample inputs
// Notes: Two-way pins resolved here from enables, bench-driven level when not enabled
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, data;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, go = 0;
  logic int_sync = 0, ls_ext = 0, serial_data_out = 0, stp = 0, p1x = 0, p3x = 0;
  logic [63:0] rl = 0, dl = 0, code, sd;
  logic [63:0] gnd = 64'h0040_0030_0020_0010;
  logic [15:0] clamp = 16'h0080;
  logic awr, wr, bv, arr, rv, ls_o, ls_oe, ls, p1_o, p1_oe, p3_o, p3_oe;
  logic t1, t3, ref_p, dat_p, ls_pin, p1_pin, p3_pin;
  logic [1:0] br, rr, resp;
  logic [3:0] act, rs, ds, sv, rseen, dseen, vseen;
  int miscompares = 0, samples_checked = 0;
  assign ls_pin = ls_oe ? ls_o : ls_ext;
  assign p1_pin = p1_oe ? p1_o : p1x;
  assign p3_pin = p3_oe ? p3_o : p3x;
  afe_input_mode_and_pin_select dut (.SYS_CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .INT_LINE_SYNC(int_sync),
    .LINE_SYNC_PIN_I(ls_pin), .LINE_SYNC_PIN_O(ls_o),
    .LINE_SYNC_PIN_OE(ls_oe), .LINE_SYNC(ls), .SERIAL_DATA_OUT(serial_data_out),
    .STORAGE_PULSE_OUT(stp), .PORT1_PIN_I(p1_pin), .PORT1_PIN_O(p1_o),
    .PORT1_PIN_OE(p1_oe), .PORT3_PIN_I(p3_pin), .PORT3_PIN_O(p3_o),
    .PORT3_PIN_OE(p3_oe), .PORT1_TEST_IN(t1), .PORT3_TEST_IN(t3),
    .REFERENCE_SAMPLE_PULSE(ref_p), .DATA_SAMPLE_PULSE(dat_p),
    .ANALOG_INPUT_CODE(code), .INPUT_GROUND_CODE(gnd),
    .CLAMP_REFERENCE_CODE(clamp), .INPUT_ACTIVE(act), .REF_STROBE(rs),
    .DATA_STROBE(ds), .SAMPLE_VALID(sv), .SAMPLE_DATA(sd));
  afe_sensor_model sensor (.clk(clk), .rst_n(rst_n), .go(go),
    .ref_lvl(rl), .dat_lvl(dl), .ref_p(ref_p), .dat_p(dat_p), .code(code));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    bit ah, wh;
    @(posedge clk);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    ah = 0; wh = 0;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!ah && awr) begin ah = 1; awv <= 0; end
      if (!wh && wr) begin wh = 1; wv <= 0; end
      if (bv) begin resp = br; bready <= 0; return; end
    end
    chk("write timeout", 1, 0);
  endtask : axw
  task automatic axr(input logic [11:0] a);
    bit ah;
    @(posedge clk);
    araddr <= a; arv <= 1; rready <= 1; ah = 0;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (!ah && arr) begin ah = 1; arv <= 0; end
      if (rv) begin data = rd; resp = rr; rready <= 0; return; end
    end
    chk("read timeout", 1, 0);
  endtask : axr
  task automatic pix(input logic [63:0] r, d);
    @(posedge clk);
    rl <= r; dl <= d; go <= 1; rseen = 0; dseen = 0; vseen = 0;
    @(posedge clk);
    go <= 0;
    repeat (12) begin
      @(posedge clk);
      rseen |= rs; dseen |= ds; vseen |= sv;
    end
  endtask : pix
  function automatic logic [63:0] pexp(input logic [3:0] sh, pol, ren,
                                       input logic [63:0] r, d);
    logic [15:0] b, s;
    for (int i = 0; i < 4; i++) begin
      s = d[16*i+:16];
      b = sh[i] ? (ren[i] ? clamp : gnd[16*i+:16]) : r[16*i+:16];
      pexp[16*i+:16] = pol[i] ? b - s : s - b;
    end
  endfunction : pexp
  task automatic t_reset;
    logic [31:0] ev [4] = '{32'h0, 32'h0, 32'h0f, 32'h0};
    chk("sync oe", ls_oe, 1);
    chk("port oe", {p1_oe, p3_oe}, 0);
    for (int i = 0; i < 4; i++) begin
      axr(12'(4 * i));
      chk("reset value", {resp, data}, {2'h0, ev[i]});
    end
    axr(12'h010);
    chk("unmapped read", {resp, data}, {2'h2, 32'h0});
    axw(12'h010, 32'hffff);
    chk("unmapped write", resp, 2'h2);
  endtask : t_reset
  task automatic t_sync;
    int_sync <= 1; cyc(3);
    chk("int sync out", {ls_oe, ls_o, ls}, 3'b111);
    axw(12'h000, 32'h1); int_sync <= 0; ls_ext <= 1; cyc(3);
    chk("ext sync in", {ls_oe, ls}, 2'b01);
    axw(12'h000, 32'h3); cyc(3);
    chk("sync low pol", ls, 0);
    ls_ext <= 0; cyc(3);
    chk("sync low pol", ls, 1);
    axw(12'h000, 32'h0);
  endtask : t_sync
  task automatic t_ports;
    logic [1:0] f;
    axw(12'h00c, 32'h1); serial_data_out <= 0; stp <= 1; p1x <= 1; p3x <= 1;
    for (int i = 0; i < 4; i++) begin
      f = 2'(i);
      axw(12'h000, {26'h0, f, f, 2'h0}); cyc(3);
      chk("port oe", {p1_oe, p3_oe}, {2{f[0]}});
      chk("test in", {t1, t3}, {2{f == 2'h2}});
      if (f[0])
        chk("port out", {p1_o, p3_o}, {f[1] ? 2'b01 : 2'b10});
    end
    axw(12'h000, 32'h0);
    axr(12'h008);
    chk("status", data, 32'h6f);
    axr(12'h00c);
    chk("gpo readback", data, 32'h1);
    p1x <= 0;
    p3x <= 0;
  endtask : t_ports
  task automatic t_count;
    logic [3:0] ex [4] = '{4'hf, 4'h7, 4'h5, 4'hf};
    for (int c = 0; c < 4; c++) begin
      axw(12'h004, 32'(c)); cyc(2);
      chk("active", act, ex[c]);
      pix(64'h0100_0100_0100_0100, 64'h0900_0900_0900_0900);
      chk("standby quiet", {rseen, dseen, vseen}, {3{ex[c]}});
    end
    axw(12'h004, 32'h0);
  endtask : t_count
  task automatic t_cds;
    logic [63:0] r = 64'h0400_0300_0200_0100, d = 64'h4444_3333_2222_1111;
    axw(12'h004, 32'h0500);
    pix(r, d);
    chk("cds strobes", {rseen, dseen, vseen}, 12'hfff);
    chk("cds value", sd, pexp(4'h0, 4'h5, 4'h0, r, d));
  endtask : t_cds
  task automatic t_sh;
    logic [63:0] r = 64'h7777_7777_7777_7777, d = 64'h4444_3333_2222_1111;
    axw(12'h004, 32'h30f0);
    pix(r, d);
    chk("sh strobes", {rseen, dseen, vseen}, 12'h0ff);
    chk("sh value", sd, pexp(4'hf, 4'h0, 4'h3, r, d));
  endtask : t_sh
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_sync();
    t_ports();
    t_count();
    t_cds();
    t_sh();
    summarize();
  end
  initial begin
    // Whole sequence needs well under 2000 cycles
    #200000;
    miscompares++;
    summarize();
  end
endmodule : tb
`default_nettype wire

// [verilog/afe_channel.sv]
// Purpose: One input channel: sampling sequence and black-level subtraction
// Assumes: Sample codes arrive synchronous to SYS_CLK
// Notes: Analog values are modelled as unsigned codes
`default_nettype none
`include "afe_params.svh"
module afe_channel
  import afe_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic active,
  input wire logic sh_mode,
  input wire logic invert,
  input wire logic ref_en,
  input wire logic ref_pulse,
  input wire logic data_pulse,
  input wire logic [WIDTH-1:0] sig_code,
  input wire logic [WIDTH-1:0] gnd_code,
  input wire logic [WIDTH-1:0] clamp_code,
  output logic ref_strobe,
  output logic data_strobe,
  output afe_sample_s sample
);
  if (WIDTH != 16) begin : g_bad_width
    $error("afe_channel: WIDTH must be 16");
  end
  logic [WIDTH-1:0] ref_r;
  logic [WIDTH-1:0] black;
  logic [WIDTH-1:0] diff;
  afe_smp_e state_r;
  function automatic logic [WIDTH-1:0] sub(input logic [WIDTH-1:0] a,
                                           input logic [WIDTH-1:0] b,
                                           input logic inv);
    sub = inv ? (b - a) : (a - b);
  endfunction : sub
  // Standby gates both strobes at the source
  assign ref_strobe = active & ~sh_mode & ref_pulse;
  assign data_strobe = active & data_pulse;
  // Single sample-hold ignores the reference pulse entirely
  assign black = ref_en ? clamp_code : gnd_code;
  assign diff = sh_mode ? sub(sig_code, black, invert)
                        : sub(sig_code, ref_r, invert);
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ref_r <= 16'h0000;
    end else if (ref_strobe) begin
      ref_r <= sig_code;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= AFE_SMP_IDLE;
    end else begin
      case (state_r)
        AFE_SMP_IDLE: if (ref_strobe) state_r <= AFE_SMP_DATA;
        AFE_SMP_DATA: if (data_strobe || !active) state_r <= AFE_SMP_IDLE;
        default: state_r <= AFE_SMP_IDLE;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sample <= '0;
    end else begin
      sample.valid <= data_strobe;
      if (data_strobe) sample.value <= diff;
    end
  end
  property p_cds_diff;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (data_strobe && !sh_mode && !invert) |=>
      sample.valid && sample.value == $past(sig_code) - $past(ref_r);
  endproperty
  a_cds_diff: assert property (p_cds_diff)
    else $error("double sampling difference wrong");
  property p_sh_black;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (data_strobe && sh_mode && !invert) |=>
      sample.value == $past(sig_code) - $past(black);
  endproperty
  a_sh_black: assert property (p_sh_black)
    else $error("sample-hold difference wrong");
  property p_sh_noref;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (sh_mode && ref_pulse) |-> !ref_strobe ##1 $stable(ref_r);
  endproperty
  a_sh_noref: assert property (p_sh_noref)
    else $error("sample-hold took a reference sample");
  // Reference must be held before a double-sampling data capture
  property p_cds_order;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (data_strobe && !sh_mode) |-> state_r == AFE_SMP_DATA;
  endproperty
  a_cds_order: assert property (p_cds_order)
    else $error("data sample without reference sample");
endmodule : afe_channel
`default_nettype wire

// [verilog/afe_input_mode_and_pin_select.sv]
// Purpose: Input mode, sampling control and shared pin function select
// Assumes: AXI4-Lite slave, one write and one read at a time
// Notes: Two-way pins are split into input, output and output enable
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
`include "afe_params.svh"
module afe_input_mode_and_pin_select
  import afe_pkg::*;
#(
  parameter int NUM_IN = 4,
  parameter int WIDTH = 16
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic INT_LINE_SYNC,
  input wire logic LINE_SYNC_PIN_I,
  output logic LINE_SYNC_PIN_O,
  output logic LINE_SYNC_PIN_OE,
  output logic LINE_SYNC,
  input wire logic SERIAL_DATA_OUT,
  input wire logic STORAGE_PULSE_OUT,
  input wire logic PORT1_PIN_I,
  output logic PORT1_PIN_O,
  output logic PORT1_PIN_OE,
  input wire logic PORT3_PIN_I,
  output logic PORT3_PIN_O,
  output logic PORT3_PIN_OE,
  output logic PORT1_TEST_IN,
  output logic PORT3_TEST_IN,
  input wire logic REFERENCE_SAMPLE_PULSE,
  input wire logic DATA_SAMPLE_PULSE,
  input wire logic [NUM_IN*WIDTH-1:0] ANALOG_INPUT_CODE,
  input wire logic [NUM_IN*WIDTH-1:0] INPUT_GROUND_CODE,
  input wire logic [WIDTH-1:0] CLAMP_REFERENCE_CODE,
  output logic [NUM_IN-1:0] INPUT_ACTIVE,
  output logic [NUM_IN-1:0] REF_STROBE,
  output logic [NUM_IN-1:0] DATA_STROBE,
  output logic [NUM_IN-1:0] SAMPLE_VALID,
  output logic [NUM_IN*WIDTH-1:0] SAMPLE_DATA
);
  if (NUM_IN != 4 || WIDTH != 16) begin : g_bad_param
    $error("NUM_IN must be 4 and WIDTH must be 16");
  end
  

  // Configuration registers
  logic line_sync_dir_sel_r;
  logic line_sync_polarity_r;
  logic [1:0] port1_function_sel_r;
  logic [1:0] port3_function_sel_r;
  logic [1:0] input_count_sel_r;
  logic [3:0] input_sampling_mode_r;
  logic [3:0] input_polarity_r;
  logic [3:0] internal_black_ref_enable_r;
  logic port1_output_r;
  logic port3_output_r;

  // Write channel state
  logic aw_got_r;
  logic w_got_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire;
  logic wr_ok;

  function automatic logic [3:0] active_mask(input logic [1:0] cnt);
    case (cnt)
      `AFE_CNT_FOUR: active_mask = 4'hf;
      `AFE_CNT_THREE: active_mask = 4'h7;
      `AFE_CNT_TWO: active_mask = 4'h5;
      default: active_mask = 4'hf;
    endcase
  endfunction : active_mask

  function automatic logic known_addr(input logic [11:0] a);
    known_addr = (a == `AFE_OFF_PIN) || (a == `AFE_OFF_INPUT) ||
                 (a == `AFE_OFF_STATUS) || (a == `AFE_OFF_GPO);
  endfunction : known_addr

  assign wr_fire = aw_got_r && w_got_r && !S_AXI_BVALID;
  assign wr_ok = known_addr(aw_addr_r);

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 12'h000;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got_r <= 1'b1;
      aw_addr_r <= {S_AXI_AWADDR[11:2], 2'h0};
      S_AXI_AWREADY <= 1'b0;
    end else if (wr_fire) begin
      aw_got_r <= 1'b0;
    end else if (!aw_got_r && !S_AXI_BVALID) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_got_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got_r <= 1'b1;
      w_data_r <= S_AXI_WDATA;
      w_strb_r <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else if (wr_fire) begin
      w_got_r <= 1'b0;
    end else if (!w_got_r && !S_AXI_BVALID) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `AFE_RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_ok ? `AFE_RESP_OKAY : `AFE_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Only byte lane 0 and 1 carry fields; status word is read only
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      line_sync_dir_sel_r <= 1'b0;
      line_sync_polarity_r <= 1'b0;
      port1_function_sel_r <= `AFE_FN_IN;
      port3_function_sel_r <= `AFE_FN_IN;
      input_count_sel_r <= `AFE_CNT_FOUR;
      input_sampling_mode_r <= 4'h0;
      input_polarity_r <= 4'h0;
      internal_black_ref_enable_r <= 4'h0;
      port1_output_r <= 1'b0;
      port3_output_r <= 1'b0;
    end else if (wr_fire && w_strb_r[0]) begin
      case (aw_addr_r)
        `AFE_OFF_PIN: begin
          line_sync_dir_sel_r <= w_data_r[`AFE_PIN_DIR];
          line_sync_polarity_r <= w_data_r[`AFE_PIN_POL];
          port1_function_sel_r <= w_data_r[`AFE_PIN_P1_LO +: 2];
          port3_function_sel_r <= w_data_r[`AFE_PIN_P3_LO +: 2];
        end
        `AFE_OFF_INPUT: begin
          input_count_sel_r <= w_data_r[`AFE_IN_CNT_LO +: 2];
          input_sampling_mode_r <= w_data_r[`AFE_IN_MODE_LO +: 4];
          if (w_strb_r[1]) begin
            input_polarity_r <= w_data_r[`AFE_IN_POL_LO +: 4];
            internal_black_ref_enable_r <= w_data_r[`AFE_IN_REF_LO +: 4];
          end
        end
        `AFE_OFF_GPO: begin
          port1_output_r <= w_data_r[`AFE_GPO_P1];
          port3_output_r <= w_data_r[`AFE_GPO_P3];
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel: one cycle from address to data
  logic [31:0] rd_word;
  logic [11:0] rd_addr;
  assign rd_addr = {S_AXI_ARADDR[11:2], 2'h0};
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_addr)
      `AFE_OFF_PIN: begin
        rd_word[`AFE_PIN_DIR] = line_sync_dir_sel_r;
        rd_word[`AFE_PIN_POL] = line_sync_polarity_r;
        rd_word[`AFE_PIN_P1_LO +: 2] = port1_function_sel_r;
        rd_word[`AFE_PIN_P3_LO +: 2] = port3_function_sel_r;
      end
      `AFE_OFF_INPUT: begin
        rd_word[`AFE_IN_CNT_LO +: 2] = input_count_sel_r;
        rd_word[`AFE_IN_MODE_LO +: 4] = input_sampling_mode_r;
        rd_word[`AFE_IN_POL_LO +: 4] = input_polarity_r;
        rd_word[`AFE_IN_REF_LO +: 4] = internal_black_ref_enable_r;
      end
      `AFE_OFF_STATUS: begin
        rd_word[`AFE_ST_ACT_LO +: 4] = INPUT_ACTIVE;
        rd_word[`AFE_ST_SYNC] = LINE_SYNC;
        rd_word[`AFE_ST_P1] = PORT1_PIN_I;
        rd_word[`AFE_ST_P3] = PORT3_PIN_I;
      end
      `AFE_OFF_GPO: begin
        rd_word[`AFE_GPO_P1] = port1_output_r;
        rd_word[`AFE_GPO_P3] = port3_output_r;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `AFE_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= known_addr(rd_addr) ? `AFE_RESP_OKAY
                                         : `AFE_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Shared pins, registered so each output comes from a flip-flop
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LINE_SYNC_PIN_O <= 1'b0;
      LINE_SYNC_PIN_OE <= 1'b1;
      LINE_SYNC <= 1'b0;
    end else begin
      LINE_SYNC_PIN_O <= INT_LINE_SYNC;
      LINE_SYNC_PIN_OE <= !line_sync_dir_sel_r;
      LINE_SYNC <= line_sync_dir_sel_r
                   ? (LINE_SYNC_PIN_I ^ line_sync_polarity_r)
                   : INT_LINE_SYNC;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PORT1_PIN_O <= 1'b0;
      PORT1_PIN_OE <= 1'b0;
      PORT1_TEST_IN <= 1'b0;
    end else begin
      PORT1_PIN_OE <= port1_function_sel_r == `AFE_FN_OUT ||
                      port1_function_sel_r == `AFE_FN_ALT;
      PORT1_PIN_O <= (port1_function_sel_r == `AFE_FN_ALT)
                     ? SERIAL_DATA_OUT : port1_output_r;
      PORT1_TEST_IN <= (port1_function_sel_r == `AFE_FN_TEST) &&
                       PORT1_PIN_I;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PORT3_PIN_O <= 1'b0;
      PORT3_PIN_OE <= 1'b0;
      PORT3_TEST_IN <= 1'b0;
    end else begin
      PORT3_PIN_OE <= port3_function_sel_r == `AFE_FN_OUT ||
                      port3_function_sel_r == `AFE_FN_ALT;
      PORT3_PIN_O <= (port3_function_sel_r == `AFE_FN_ALT)
                     ? STORAGE_PULSE_OUT : port3_output_r;
      PORT3_TEST_IN <= (port3_function_sel_r == `AFE_FN_TEST) &&
                       PORT3_PIN_I;
    end
  end

  // Channel bank; the active mask is registered to keep outputs clean
  logic [3:0] act;
  logic [3:0] ref_s;
  logic [3:0] dat_s;
  afe_sample_s smp [NUM_IN];
  assign act = active_mask(input_count_sel_r);

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INPUT_ACTIVE <= 4'hf;
      REF_STROBE <= 4'h0;
      DATA_STROBE <= 4'h0;
    end else begin
      INPUT_ACTIVE <= act;
      REF_STROBE <= ref_s;
      DATA_STROBE <= dat_s;
    end
  end

  for (genvar i = 0; i < NUM_IN; i++) begin : g_ch
    afe_channel #(.WIDTH(WIDTH)) u_ch (
      .SYS_CLK(SYS_CLK),
      .RESET_N(RESET_N),
      .active(act[i]),
      .sh_mode(input_sampling_mode_r[i]),
      .invert(input_polarity_r[i]),
      .ref_en(internal_black_ref_enable_r[i]),
      .ref_pulse(REFERENCE_SAMPLE_PULSE),
      .data_pulse(DATA_SAMPLE_PULSE),
      .sig_code(ANALOG_INPUT_CODE[i*WIDTH +: WIDTH]),
      .gnd_code(INPUT_GROUND_CODE[i*WIDTH +: WIDTH]),
      .clamp_code(CLAMP_REFERENCE_CODE),
      .ref_strobe(ref_s[i]),
      .data_strobe(dat_s[i]),
      .sample(smp[i])
    );
    assign SAMPLE_VALID[i] = smp[i].valid;
    assign SAMPLE_DATA[i*WIDTH +: WIDTH] = smp[i].value;
  end

  property p_standby_quiet;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (input_count_sel_r == `AFE_CNT_TWO) |=>
      ((REF_STROBE | DATA_STROBE | SAMPLE_VALID) & 4'ha) == 4'h0;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("standby input sampled");
  property p_count_three;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (input_count_sel_r == `AFE_CNT_THREE) |=> INPUT_ACTIVE == 4'h7;
  endproperty
  a_count_three: assert property (p_count_three)
    else $error("three-input mask wrong");
  property p_sync_drive;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    !line_sync_dir_sel_r |=>
      LINE_SYNC_PIN_OE && LINE_SYNC == $past(INT_LINE_SYNC);
  endproperty
  a_sync_drive: assert property (p_sync_drive)
    else $error("line sync not driven");
  property p_sync_pol;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (line_sync_dir_sel_r && !line_sync_polarity_r) |=>
      !LINE_SYNC_PIN_OE && LINE_SYNC == $past(LINE_SYNC_PIN_I);
  endproperty
  a_sync_pol: assert property (p_sync_pol)
    else $error("external line sync polarity wrong");
  property p_port1_sdo;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (port1_function_sel_r == `AFE_FN_ALT) |=>
      PORT1_PIN_OE && PORT1_PIN_O == $past(SERIAL_DATA_OUT);
  endproperty
  a_port1_sdo: assert property (p_port1_sdo)
    else $error("port1 serial data not driven");
  property p_port3_in;
    @(posedge SYS_CLK) disable iff (!RESET_N)
    (port3_function_sel_r == `AFE_FN_IN) |=> !PORT3_PIN_OE;
  endproperty
  a_port3_in: assert property (p_port3_in)
    else $error("port3 driven while input");
endmodule : afe_input_mode_and_pin_select
`default_nettype wire

// [verilog/afe_params.svh]
// Purpose: Constants and rule summary for the input mode and pin select block
// Assumes: Included by every design file except the package
// Notes: Offsets are byte addresses on the AXI4-Lite slave
// Contract
// - Line-sync direction 0 drives internal sync out, 1 accepts external.
// - External line-sync polarity follows a bit; reset means active high.
// - Port1 function: 0 input, 1 output, 2 test input, 3 serial data out.
// - Port3 function: 0 input, 1 output, 2 test input, 3 storage pulse.
// - Input count 0 all four, 1 inputs 1-3, 2 inputs 1 and 3.
// - Per-input mode bit: 0 double sampling, 1 single sample-hold.
// - Each input has its own polarity setting.
// - Double sampling takes reference sample then data sample each pixel.
// - Double sampling output is data sample minus reference sample.
// - Single sample-hold samples once per pixel with the data pulse.
// - Sample-hold output is data level minus the selected black reference level.
// - Reference-enable bit selects internal clamp level as black reference.
// - Without reference enable, sample-hold uses the input ground pin.
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH
`define AFE_OFF_PIN 12'h000
`define AFE_OFF_INPUT 12'h004
`define AFE_OFF_STATUS 12'h008
`define AFE_OFF_GPO 12'h00c
`define AFE_PIN_DIR 0
`define AFE_PIN_POL 1
`define AFE_PIN_P1_LO 2
`define AFE_PIN_P3_LO 4
`define AFE_IN_CNT_LO 0
`define AFE_IN_MODE_LO 4
`define AFE_IN_POL_LO 8
`define AFE_IN_REF_LO 12
`define AFE_GPO_P1 0
`define AFE_GPO_P3 1
`define AFE_ST_ACT_LO 0
`define AFE_ST_SYNC 4
`define AFE_ST_P1 5
`define AFE_ST_P3 6
`define AFE_FN_IN 2'h0
`define AFE_FN_OUT 2'h1
`define AFE_FN_TEST 2'h2
`define AFE_FN_ALT 2'h3
`define AFE_CNT_FOUR 2'h0
`define AFE_CNT_THREE 2'h1
`define AFE_CNT_TWO 2'h2
`define AFE_RESP_OKAY 2'h0
`define AFE_RESP_SLVERR 2'h2
`endif

// [verilog/afe_pkg.sv]
// Purpose: Shared types for the input mode and pin select block
// Assumes: afe_params.svh holds the numbers
// Notes: Sample carrier groups the per-input channel data
`default_nettype none
package afe_pkg;
  typedef enum logic [1:0] {
    AFE_SMP_IDLE = 2'b01,
    AFE_SMP_DATA = 2'b10
  } afe_smp_e;
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } afe_sample_s;
endpackage : afe_pkg
`default_nettype wire
